// *** test/btr_slave_model.sv ***
// Purpose: Far-side slave answering bus cycles with termination pulses
// Assumes: Bench picks mode and delay before each request
// Notes:   Modes 0 silent, 1 ack, 2 err+ack, 3 retry, 4 ack+inhibit
`timescale 1ns/10ps
module btr_slave_model (
  input  wire logic                       clk,
  input  wire logic                       xfer_start_n,
  input  wire logic                       burst_more_beats_n,
  input  wire logic [2:0]                 mode,
  input  wire logic [3:0]                 delay,
  input  wire logic [btr_pkg::DATA_W-1:0] data,
  output btr_pkg::btr_term_in_t           term_in,
  output logic [btr_pkg::DATA_W-1:0]      bus_data_in
);
  int   beats;
  int   started = 0;
  int   served  = 0;
  logic more;

  // Starts counted on the falling edge, none missed while busy
  always @(negedge clk) begin
    if (!xfer_start_n) started++;
  end

  initial begin
    term_in     = '1;
    bus_data_in = 32'h00000000;
    forever begin
      @(posedge clk);
      if (started != served) begin
        served = started;
        if (mode != 3'h0) begin
          beats = 0;
          do begin
            // Drive only once the own address phase is over
            repeat (delay) @(negedge clk);
            @(negedge clk);
            more = !burst_more_beats_n;
            bus_data_in = data + beats;
            term_in.xfer_ack_n = !(mode == 3'h1 || mode == 3'h2 ||
                                   mode == 3'h4);
            term_in.xfer_err_ack_n = (mode != 3'h2);
            term_in.retry_or_kill_reservation_n = (mode != 3'h3);
            term_in.burst_inhibit_n = (mode != 3'h4);
            // Two clocks, so the master's synchroniser keeps it
            repeat (2) @(negedge clk);
            // Pull-ups take the lines once released
            term_in = '1;
            repeat (4) @(negedge clk);
            bus_data_in = ~bus_data_in;
            beats++;
          end while (beats < 4 && more && mode == 3'h1);
        end
      end
    end
  end
endmodule // btr_slave_model

// *** test/bus_termination_and_reservation_bench.sv ***
// Purpose: Self-checking bench for the bus master block
// Assumes: Slave model on the bus side, core driven by tasks
// Notes:   Inputs change on the falling edge
`timescale 1ns/10ps
module bus_termination_and_reservation_bench;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic                   req_valid = 1'b0;
  btr_pkg::btr_req_t      req = '0;
  logic                   req_ready, rsp_valid, rsv_flag, xfer_start_n;
  btr_pkg::btr_rsp_t      rsp;
  btr_pkg::btr_term_in_t  term_in;
  logic                   cancel_reservation_n = 1'b1;
  logic [31:0]            bus_data_in, bus_addr, bus_data_out, s_data;
  logic                   bus_read, burst_more_beats_n, show_cycle_n;
  logic                   bus_data_oe_n;
  logic [2:0]             s_mode = 3'h0;
  logic [3:0]             s_delay = 4'h0;
  int                     mismatches = 0, n_tests = 0, starts, i, k;
  int                     seed = 32'h222113BB;
  logic                   oe_seen, burst_more_beats_n_seen;
  logic                   rd_seen, bst_seen, bst_last, bus_burst_n;
  logic [31:0]            dout_seen;
  logic [31:0]            addrs[$];

  always #5 clk = ~clk;

  btr_bus_master dut_u (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .rsv_flag(rsv_flag), .term_in(term_in),
    .cancel_reservation_n(cancel_reservation_n),
    .bus_data_in(bus_data_in), .xfer_start_n(xfer_start_n),
    .bus_addr(bus_addr), .bus_read(bus_read), .bus_burst_n(bus_burst_n),
    .burst_more_beats_n(burst_more_beats_n), .show_cycle_n(show_cycle_n),
    .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n));

  btr_slave_model slave_u (.clk(clk), .xfer_start_n(xfer_start_n),
    .burst_more_beats_n(burst_more_beats_n), .mode(s_mode),
    .delay(s_delay), .data(s_data), .term_in(term_in),
    .bus_data_in(bus_data_in));

  // Bus activity seen during one request
  always @(posedge clk) begin
    if (!xfer_start_n) begin
      starts++;
      addrs.push_back(bus_addr);
      rd_seen = bus_read;
      if (starts == 1) bst_seen = !bus_burst_n;
      bst_last = !bus_burst_n;
    end
    if (!bus_data_oe_n) dout_seen = bus_data_out;
    if (!bus_data_oe_n && !show_cycle_n) oe_seen = 1'b1;
    if (!burst_more_beats_n) burst_more_beats_n_seen = 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Termination expected for the answering slave modes 1 to 4
  function automatic btr_pkg::btr_term_t exp_term(input logic [2:0] m);
    case (m)
      3'h2:    exp_term = btr_pkg::BTR_TERM_ERROR;
      3'h3:    exp_term = btr_pkg::BTR_TERM_RETRY;
      default: exp_term = btr_pkg::BTR_TERM_NORMAL;
    endcase
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic op(input btr_pkg::btr_kind_t kd, input logic b,
                    input logic [31:0] a, input logic [2:0] m);
    @(negedge clk);
    s_mode = m;
    req = '{kind: kd, burst: b, addr: a, wdata: a ^ 32'h5A5A0000};
    req_valid = 1'b1;
    starts = 0;
    oe_seen = 1'b0;
    burst_more_beats_n_seen = 1'b0;
    dout_seen = 32'h00000000;
    addrs.delete();
    @(negedge clk);
    req_valid = 1'b0;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) break;
    end
    if (k == 300) begin
      mismatches++;
      $display("BAD t=%0t no response", $time);
      tally_and_finish();
    end
    repeat (8) @(negedge clk);
  endtask

  task automatic cancel;
    @(negedge clk);
    cancel_reservation_n = 1'b0;
    repeat (3) @(negedge clk);
    cancel_reservation_n = 1'b1;
    for (k = 0; k < 10 && rsv_flag !== 1'b0; k++) @(negedge clk);
  endtask

  initial begin
    s_data = 32'hC0DE1234;
    repeat (20) @(negedge clk);
    check(req_ready, 1'b1);
    check(rsp_valid, 1'b0);
    check(rsv_flag, 1'b0);
    check(xfer_start_n, 1'b1);
    rst_b = 1'b1;
    $display("reset test done");

    op(btr_pkg::BTR_KIND_SHOW_INSTR, 1'b0, 32'h00001000, 3'h0);
    check(starts, 1);
    op(btr_pkg::BTR_KIND_SHOW_DATA, 1'b1, 32'h00001010, 3'h0);
    check(starts, 1);
    check(oe_seen, 1'b1);
    check(burst_more_beats_n_seen, 1'b0);
    check(dout_seen, 32'h00001010 ^ 32'h5A5A0000);
    $display("show cycle test done");

    for (i = 1; i <= 3; i++) begin
      op(btr_pkg::BTR_KIND_READ, 1'b0, 32'h00002000, i[2:0]);
      check(rsp.term, exp_term(i[2:0]));
    end
    check(rsp.term, btr_pkg::BTR_TERM_RETRY);
    $display("termination test done");

    op(btr_pkg::BTR_KIND_READ, 1'b1, 32'h00003000, 3'h1);
    check(burst_more_beats_n_seen, 1'b1);
    check(starts, 1);
    check(rsp.rdata, s_data);
    check(bst_seen, 1'b1);
    check(rd_seen, 1'b1);
    op(btr_pkg::BTR_KIND_READ, 1'b1, 32'h00004000, 3'h4);
    check(starts, 4);
    check(bst_seen, 1'b1);
    check(bst_last, 1'b0);
    for (i = 0; i < addrs.size(); i++)
      check(addrs[i], 32'h00004000 + i * btr_pkg::ADDR_STEP);
    $display("burst test done");

    op(btr_pkg::BTR_KIND_LOAD_RSV, 1'b0, 32'h00005000, 3'h1);
    check(rsv_flag, 1'b1);
    op(btr_pkg::BTR_KIND_WRITE, 1'b0, 32'h00005000, 3'h1);
    check(rsv_flag, 1'b1);
    cancel();
    check(rsv_flag, 1'b0);
    op(btr_pkg::BTR_KIND_STORE_COND, 1'b0, 32'h00005000, 3'h1);
    check(starts, 0);
    check(rsp.sc_fail, 1'b1);
    op(btr_pkg::BTR_KIND_LOAD_RSV, 1'b0, 32'h00005000, 3'h1);
    op(btr_pkg::BTR_KIND_LOAD_RSV, 1'b0, 32'h00005004, 3'h1);
    check(rsv_flag, 1'b1);
    op(btr_pkg::BTR_KIND_STORE_COND, 1'b0, 32'h00005004, 3'h1);
    check(starts, 1);
    check(rsp.sc_fail, 1'b0);
    check(rsv_flag, 1'b0);
    op(btr_pkg::BTR_KIND_LOAD_RSV, 1'b0, 32'h00005008, 3'h1);
    op(btr_pkg::BTR_KIND_STORE_COND, 1'b0, 32'h00005008, 3'h3);
    check(rsp.sc_fail, 1'b1);
    $display("reservation test done");

    for (i = 0; i < 20; i++) begin
      s_data = $random(seed);
      s_delay = 4'($random(seed));
      op(i[0] ? btr_pkg::BTR_KIND_WRITE : btr_pkg::BTR_KIND_READ, 1'b0,
         {s_data[31:2], 2'h0}, 3'h1);
      check(rsp.term, btr_pkg::BTR_TERM_NORMAL);
      if (!i[0]) check(rsp.rdata, s_data);
      check(rd_seen, !i[0]);
      if (i[0]) check(dout_seen, {s_data[31:2], 2'h0} ^ 32'h5A5A0000);
    end
    $display("random test done");
    tally_and_finish();
  end
endmodule // bus_termination_and_reservation_bench

// *** verilog/btr_bus_master.sv ***
// Purpose: External bus master termination, show cycles and reservation
// Assumes: Bus termination and cancel inputs come from outside and pass a 3-stage synchroniser
// Notes:   Show-cycle data is driven by this master for reads and writes
// How it works
// - Show cycle: one address, optional data phase
// - Master drives show-cycle data, reads too
// - Show address and data valid one clock
// - Show data phase needs no acknowledge
// - Burst show presents first beat only
// - More-beats asserted while another beat follows
// - Burst inhibit: split into single incrementing transfers
// - Error acknowledge aborts, beats all others
// - Priority decode: error, normal, retry
// - Load-reserve sets the single reservation flag
// - Own store-conditional clears the flag
// - Own ordinary store keeps the flag
// - Foreign store clears; failed conditional no write
// - Cancel sampled each edge clears flag
// - Store-conditional without flag: no cycle, fail
// - Retry after first acked beat means error
`timescale 1ns/10ps
module btr_bus_master (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      req_valid,
  input  wire btr_pkg::btr_req_t         req,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output btr_pkg::btr_rsp_t              rsp,
  output logic                           rsv_flag,
  input  wire btr_pkg::btr_term_in_t     term_in,
  input  wire logic                      cancel_reservation_n,
  input  wire logic [btr_pkg::DATA_W-1:0] bus_data_in,
  output logic                           xfer_start_n,
  output logic [btr_pkg::ADDR_W-1:0]     bus_addr,
  output logic                           bus_read,
  output logic                           bus_burst_n,
  output logic                           burst_more_beats_n,
  output logic                           show_cycle_n,
  output logic [btr_pkg::DATA_W-1:0]     bus_data_out,
  output logic                           bus_data_oe_n
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_DATA, ST_SHOW_ADDR, ST_SHOW_DATA, ST_DONE
  } btr_state_t;

  // Three-flop synchronisers for the five external inputs
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [NSYNC-1:0] s1_next, s2_next, s3_next, filt_next;
  logic [NSYNC-1:0] filt_d_reg, filt_d_next;
  logic [btr_pkg::DATA_W-1:0] din_reg;

  assign raw_in = {cancel_reservation_n, term_in.xfer_err_ack_n,
                   term_in.xfer_ack_n, term_in.retry_or_kill_reservation_n,
                   term_in.burst_inhibit_n};

  always_comb begin
    s1_next = raw_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    filt_next = filt_reg;
    filt_d_next = filt_reg;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_reg   <= 5'h1F;
      s2_reg   <= 5'h1F;
      s3_reg   <= 5'h1F;
      filt_reg <= 5'h1F;
      filt_d_reg <= 5'h1F;
      din_reg  <= btr_pkg::DATA_RST;
    end else begin
      s1_reg   <= s1_next;
      s2_reg   <= s2_next;
      s3_reg   <= s3_next;
      filt_reg <= filt_next;
      filt_d_reg <= filt_d_next;
      din_reg  <= bus_data_in;
    end
  end

  logic cancel_a, err_a, ack_a, retry_a, inhibit_a;
  assign cancel_a  = !filt_reg[4];
  // Error, ack and retry act once, on the first synced low cycle; inhibit acts as a level
  assign err_a     = !filt_reg[3] && filt_d_reg[3];
  assign ack_a     = !filt_reg[2] && filt_d_reg[2];
  assign retry_a   = !filt_reg[1] && filt_d_reg[1];
  assign inhibit_a = !filt_reg[0];

  function automatic btr_pkg::btr_term_t decode_term(
    input logic err, input logic ack, input logic rty);
    if (err) begin
      decode_term = btr_pkg::BTR_TERM_ERROR;
    end else if (ack) begin
      decode_term = btr_pkg::BTR_TERM_NORMAL;
    end else if (rty) begin
      decode_term = btr_pkg::BTR_TERM_RETRY;
    end else begin
      decode_term = btr_pkg::BTR_TERM_NONE;
    end
  endfunction

  btr_state_t                  st_reg, st_next;
  btr_pkg::btr_req_t           cur_reg, cur_next;
  logic [2:0]                  beat_reg, beat_next;
  logic                        acked_reg, acked_next;
  logic                        split_reg, split_next;
  logic                        rsv_reg, rsv_next;
  logic                        rdy_reg, rdy_next;
  logic                        rv_reg, rv_next;
  btr_pkg::btr_rsp_t           rsp_reg, rsp_next;
  logic                        ts_reg, ts_next;
  logic [btr_pkg::ADDR_W-1:0]  addr_reg, addr_next;
  logic                        rd_reg, rd_next;
  logic                        bst_reg, bst_next;
  logic                        more_reg, more_next;
  logic                        show_reg, show_next;
  logic [btr_pkg::DATA_W-1:0]  dout_reg, dout_next;
  logic                        oe_reg, oe_next;
  btr_pkg::btr_term_t          term;
  logic                        multi;
  logic                        last_beat;

  assign term  = decode_term(err_a, ack_a, retry_a);
  assign multi = cur_reg.burst;
  assign last_beat = (beat_reg == btr_pkg::BEATS_BURST - 3'h1);

  always_comb begin
    st_next    = st_reg;
    cur_next   = cur_reg;
    beat_next  = beat_reg;
    acked_next = acked_reg;
    split_next = split_reg;
    rsv_next   = rsv_reg;
    rdy_next   = 1'b0;
    rv_next    = 1'b0;
    rsp_next   = rsp_reg;
    ts_next    = 1'b1;
    addr_next  = addr_reg;
    rd_next    = rd_reg;
    bst_next   = 1'b1;
    more_next  = 1'b1;
    show_next  = 1'b1;
    dout_next  = dout_reg;
    oe_next    = 1'b1;
    case (st_reg)
      ST_IDLE: begin
        rdy_next = !(req_valid && rdy_reg);
        if (req_valid && rdy_reg) begin
          cur_next   = req;
          beat_next  = 3'h0;
          acked_next = 1'b0;
          split_next = 1'b0;
          addr_next  = req.addr;
          rsp_next.rdata   = btr_pkg::DATA_RST;
          rsp_next.sc_fail = 1'b0;
          rsp_next.term    = btr_pkg::BTR_TERM_NORMAL;
          if (req.kind == btr_pkg::BTR_KIND_SHOW_INSTR ||
              req.kind == btr_pkg::BTR_KIND_SHOW_DATA) begin
            st_next   = ST_SHOW_ADDR;
            ts_next   = 1'b0;
            show_next = 1'b0;
            rd_next   = 1'b0;
          end else if (req.kind == btr_pkg::BTR_KIND_STORE_COND &&
                       !rsv_reg) begin
            st_next = ST_DONE;
            rsp_next.sc_fail = 1'b1;
          end else begin
            st_next   = ST_ADDR;
            ts_next   = 1'b0;
            rd_next   = (req.kind == btr_pkg::BTR_KIND_READ ||
                         req.kind == btr_pkg::BTR_KIND_LOAD_RSV);
            bst_next  = !req.burst;
            more_next = !req.burst;
            dout_next = req.wdata;
            oe_next   = rd_next;
          end
          if (req.kind == btr_pkg::BTR_KIND_STORE_COND) begin
            rsv_next = 1'b0;
          end
        end
      end
      ST_SHOW_ADDR: begin
        if (cur_reg.kind == btr_pkg::BTR_KIND_SHOW_INSTR) begin
          st_next = ST_DONE;
        end else begin
          st_next   = ST_SHOW_DATA;
          show_next = 1'b0;
          dout_next = cur_reg.wdata;
          oe_next   = 1'b0;
        end
      end
      ST_SHOW_DATA: begin
        st_next = ST_DONE;
      end
      ST_ADDR: begin
        st_next   = ST_DATA;
        bst_next  = bst_reg;
        more_next = more_reg;
        oe_next   = oe_reg;
      end
      ST_DATA: begin
        bst_next  = bst_reg;
        more_next = more_reg;
        oe_next   = oe_reg;
        case (term)
          btr_pkg::BTR_TERM_ERROR: begin
            st_next = ST_DONE;
            rsp_next.term = btr_pkg::BTR_TERM_ERROR;
          end
          btr_pkg::BTR_TERM_RETRY: begin
            st_next = ST_DONE;
            rsp_next.term = acked_reg ? btr_pkg::BTR_TERM_ERROR
                                      : btr_pkg::BTR_TERM_RETRY;
            if (cur_reg.kind == btr_pkg::BTR_KIND_STORE_COND) begin
              rsp_next.sc_fail = 1'b1;
            end
          end
          btr_pkg::BTR_TERM_NORMAL: begin
            acked_next = 1'b1;
            if (rd_reg && !acked_reg) begin
              rsp_next.rdata = din_reg;
            end
            if (cur_reg.kind == btr_pkg::BTR_KIND_LOAD_RSV) begin
              rsv_next = 1'b1;
            end
            if (!multi || last_beat) begin
              st_next = ST_DONE;
            end else begin
              beat_next = beat_reg + 3'h1;
              more_next = (beat_next == btr_pkg::BEATS_BURST - 3'h1);
              if (inhibit_a || split_reg) begin
                split_next = 1'b1;
                addr_next  = addr_reg + btr_pkg::ADDR_STEP;
                st_next    = ST_ADDR;
                ts_next    = 1'b0;
                bst_next   = 1'b1;
                more_next  = 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
      ST_DONE: begin
        st_next  = ST_IDLE;
        rv_next  = 1'b1;
        rdy_next = 1'b1;
      end
      default: st_next = ST_IDLE;
    endcase
    if (cancel_a) begin
      rsv_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg    <= ST_IDLE;
      cur_reg   <= '0;
      beat_reg  <= 3'h0;
      acked_reg <= 1'b0;
      split_reg <= 1'b0;
      rsv_reg   <= 1'b0;
      rdy_reg   <= 1'b1;
      rv_reg    <= 1'b0;
      rsp_reg   <= '0;
      ts_reg    <= 1'b1;
      addr_reg  <= btr_pkg::ADDR_RST;
      rd_reg    <= 1'b1;
      bst_reg   <= 1'b1;
      more_reg  <= 1'b1;
      show_reg  <= 1'b1;
      dout_reg  <= btr_pkg::DATA_RST;
      oe_reg    <= 1'b1;
    end else begin
      st_reg    <= st_next;
      cur_reg   <= cur_next;
      beat_reg  <= beat_next;
      acked_reg <= acked_next;
      split_reg <= split_next;
      rsv_reg   <= rsv_next;
      rdy_reg   <= rdy_next;
      rv_reg    <= rv_next;
      rsp_reg   <= rsp_next;
      ts_reg    <= ts_next;
      addr_reg  <= addr_next;
      rd_reg    <= rd_next;
      bst_reg   <= bst_next;
      more_reg  <= more_next;
      show_reg  <= show_next;
      dout_reg  <= dout_next;
      oe_reg    <= oe_next;
    end
  end

  assign req_ready          = rdy_reg;
  assign rsp_valid          = rv_reg;
  assign rsp                = rsp_reg;
  assign rsv_flag           = rsv_reg;
  assign xfer_start_n       = ts_reg;
  assign bus_addr           = addr_reg;
  assign bus_read           = rd_reg;
  assign bus_burst_n        = bst_reg;
  assign burst_more_beats_n = more_reg;
  assign show_cycle_n       = show_reg;
  assign bus_data_out       = dout_reg;
  assign bus_data_oe_n      = oe_reg;

  // Show data stands exactly one clock, then ends unacknowledged
  AST_SHOW_DATA_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_SHOW_DATA) |=> (st_reg == ST_DONE && oe_reg))
    else $error("Show data held longer than one clock");
  AST_SHOW_ADDR_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(show_reg) && !ts_reg |=> ts_reg)
    else $error("Show address held longer than one clock");
  AST_SHOW_DRIVES: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_SHOW_DATA) |-> !oe_reg && !show_reg)
    else $error("Show data not driven by master");
  AST_SC_NO_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_IDLE && req_valid && rdy_reg && !rsv_reg &&
     req.kind == btr_pkg::BTR_KIND_STORE_COND)
    |=> ts_reg ##1 (rv_reg && rsp_reg.sc_fail && ts_reg))
    else $error("Store-conditional ran without reservation");
  AST_ERR_WINS: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_DATA && err_a) |=> (st_reg == ST_DONE &&
     rsp_reg.term == btr_pkg::BTR_TERM_ERROR))
    else $error("Error termination not taken first");
  AST_RETRY_LATE: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_DATA && acked_reg && !err_a && !ack_a && retry_a)
    |=> rsp_reg.term == btr_pkg::BTR_TERM_ERROR)
    else $error("Late retry not treated as error");
  AST_CANCEL: assert property (@(posedge clk) disable iff (!rst_b)
    cancel_a |=> !rsv_reg)
    else $error("Cancel did not clear reservation");
  AST_LOAD_RSV: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_DATA && term == btr_pkg::BTR_TERM_NORMAL && !cancel_a &&
     cur_reg.kind == btr_pkg::BTR_KIND_LOAD_RSV) |=> rsv_reg)
    else $error("Load-reserve did not set reservation");
  AST_STORE_KEEPS: assert property (@(posedge clk) disable iff (!rst_b)
    (cur_reg.kind == btr_pkg::BTR_KIND_WRITE && st_reg != ST_IDLE &&
     !cancel_a) |=> rsv_reg == $past(rsv_reg))
    else $error("Ordinary store changed reservation");
  AST_SPLIT_INC: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_DATA && term == btr_pkg::BTR_TERM_NORMAL && multi &&
     !last_beat && (inhibit_a || split_reg))
    |=> !ts_reg && bst_reg && addr_reg == $past(addr_reg) +
        btr_pkg::ADDR_STEP)
    else $error("Inhibited burst not split with address step");
  AST_MORE_LAST: assert property (@(posedge clk) disable iff (!rst_b)
    (st_reg == ST_DATA && multi && last_beat) |-> more_reg)
    else $error("More-beats asserted on last beat");
endmodule // btr_bus_master

// *** verilog/btr_pkg.sv ***
// Purpose: Shared types and constants for the bus termination block
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Bus strobes are active low, bus_read high for reads; burst length fixed at four beats
package btr_pkg;
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam logic [2:0]  BEATS_BURST = 3'h4;
  localparam logic [31:0] ADDR_STEP   = 32'h00000004;
  localparam logic [31:0] ADDR_RST    = 32'h00000000;
  localparam logic [31:0] DATA_RST    = 32'h00000000;

  typedef enum logic [2:0] {
    BTR_KIND_READ,
    BTR_KIND_WRITE,
    BTR_KIND_LOAD_RSV,
    BTR_KIND_STORE_COND,
    BTR_KIND_SHOW_INSTR,
    BTR_KIND_SHOW_DATA
  } btr_kind_t;

  typedef enum logic [1:0] {
    BTR_TERM_NONE,
    BTR_TERM_NORMAL,
    BTR_TERM_ERROR,
    BTR_TERM_RETRY
  } btr_term_t;

  // Core request
  typedef struct packed {
    btr_kind_t         kind;
    logic              burst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } btr_req_t;

  // Answer to the core
  typedef struct packed {
    btr_term_t         term;
    logic              sc_fail;
    logic [DATA_W-1:0] rdata;
  } btr_rsp_t;

  // Sampled termination inputs, all active low
  typedef struct packed {
    logic xfer_err_ack_n;
    logic xfer_ack_n;
    logic retry_or_kill_reservation_n;
    logic burst_inhibit_n;
  } btr_term_in_t;
endpackage
